// *** design/arcdr_consts.svh ***
`ifndef ARCDR_CONSTS_SVH
`define ARCDR_CONSTS_SVH
`define ARCDR_OVS_NORMAL 5'h10
`define ARCDR_OVS_DOUBLE 5'h08
`define ARCDR_VOTE_NORMAL 5'h08
`define ARCDR_VOTE_DOUBLE 5'h04
`define ARCDR_LEN_MIN 4'h5
`define ARCDR_LEN_MAX 4'hA
`define ARCDR_DIV_RESET 12'h000
`endif

// *** design/arcdr_pkg.sv ***
package arcdr_pkg;
    // Receiver sequencing states, Gray coded along idle-start-data-stop.
    typedef enum logic [1:0]
    {
        ARCDR_IDLE = 2'h0,
        ARCDR_START = 2'h1,
        ARCDR_DATA = 2'h3,
        ARCDR_STOP = 2'h2
    } arcdr_state_t;
endpackage

// *** design/arcdr_fifo.sv ***
`timescale 1ns/1ps
module arcdr_fifo
#(
    parameter int WIDTH = 11,
    parameter int DEPTH = 16
)
(
    input wire logic mclk_i,
    input wire logic srst_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    logic push;
    logic pop;

    // Handshakes qualify pushes and pops against honest full and empty.
    assign in_ready_o = (count != (AW+1)'(DEPTH));
    assign out_valid_o = (count != '0);
    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;
    assign out_data_o = mem[rd_ptr];

    // Storage is written at the write index.
    always_ff @(posedge mclk_i)
    begin
        if (push)
        begin
            mem[wr_ptr] <= in_data_i;
        end
    end

    // Pointers and occupancy.
    always_ff @(posedge mclk_i)
    begin
        if (srst_i)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end
        else
        begin
            if (push)
            begin
                wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
            end
            if (pop)
            begin
                rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
            end
            count <= count + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

// *** design/arcdr_rx.sv ***
`timescale 1ns/1ps
`include "arcdr_consts.svh"
module arcdr_rx
#(
    parameter int DIVW = 12,
    parameter int FIFO_DEPTH = 16
)
(
    input wire logic mclk_i,
    input wire logic srst_i,
    input wire logic serial_in_line_i,
    input wire logic double_speed_select_i,
    input wire logic [DIVW-1:0] baud_divisor_value_i,
    input wire logic [3:0] char_len_i,
    output logic rx_valid_o,
    input wire logic rx_ready_i,
    output logic [9:0] rx_data_o,
    output logic frame_error_flag_o,
    output logic overrun_o,
    output logic busy_o
);
    logic line_meta;
    logic line_sync;
    logic [DIVW-1:0] div_cnt;
    logic tick;
    logic line_prev;
    arcdr_pkg::arcdr_state_t state;
    logic [4:0] phase;
    logic [1:0] votes;
    logic [4:0] samp;
    logic vote_bit;
    logic [3:0] bit_idx;
    logic [3:0] frame_len;
    logic [9:0] shift;
    logic [4:0] ovs;
    logic [4:0] vote_first;
    logic push_valid;
    logic [10:0] push_data;
    logic fifo_ready;
    logic [10:0] pop_data;

    // Majority of three centre samples.
    function automatic logic arcdr_major(input logic [2:0] s);
        arcdr_major = (s[0] & s[1]) | (s[1] & s[2]) | (s[0] & s[2]);
    endfunction

    // Oversampling divisor and vote window follow the speed select.
    assign ovs = double_speed_select_i ? `ARCDR_OVS_DOUBLE
                                       : `ARCDR_OVS_NORMAL;
    assign vote_first = double_speed_select_i ? `ARCDR_VOTE_DOUBLE
                                              : `ARCDR_VOTE_NORMAL;
    // Number of the sample taken at this tick, wrapping once per bit.
    assign samp = (phase == ovs) ? 5'h01 : phase + 5'h01;
    // Majority of the two stored centre samples and the current one.
    assign vote_bit = arcdr_major({votes, line_sync});
    assign busy_o = (state != arcdr_pkg::ARCDR_IDLE);

    // Two-stage synchroniser ahead of all sampling.
    always_ff @(posedge mclk_i)
    begin
        if (srst_i)
        begin
            line_meta <= 1'b1;
            line_sync <= 1'b1;
        end
        else
        begin
            line_meta <= serial_in_line_i;
            line_sync <= line_meta;
        end
    end

    // Sample tick generator: one tick per oversample period.
    always_ff @(posedge mclk_i)
    begin
        if (srst_i)
        begin
            div_cnt <= `ARCDR_DIV_RESET;
            tick <= 1'b0;
        end
        else if (div_cnt >= baud_divisor_value_i)
        begin
            div_cnt <= `ARCDR_DIV_RESET;
            tick <= 1'b1;
        end
        else
        begin
            div_cnt <= div_cnt + 1'b1;
            tick <= 1'b0;
        end
    end

    // Character plus parity length is clamped to five through ten.
    always_ff @(posedge mclk_i)
    begin
        if (srst_i)
        begin
            frame_len <= 4'h8;
        end
        else if (state == arcdr_pkg::ARCDR_IDLE)
        begin
            if (char_len_i < `ARCDR_LEN_MIN)
            begin
                frame_len <= `ARCDR_LEN_MIN;
            end
            else if (char_len_i > `ARCDR_LEN_MAX)
            begin
                frame_len <= `ARCDR_LEN_MAX;
            end
            else
            begin
                frame_len <= char_len_i;
            end
        end
    end

    // Recovery sequencer: start qualification, data bits, first stop bit.
    always_ff @(posedge mclk_i)
    begin
        if (srst_i)
        begin
            state <= arcdr_pkg::ARCDR_IDLE;
            phase <= 5'h00;
            votes <= 2'h0;
            bit_idx <= 4'h0;
            shift <= 10'h000;
            line_prev <= 1'b1;
            push_valid <= 1'b0;
            push_data <= 11'h000;
        end
        else
        begin
            push_valid <= 1'b0;
            if (tick)
            begin
                line_prev <= line_sync;
                unique case (state)
                    arcdr_pkg::ARCDR_IDLE:
                    begin
                        if (line_prev && !line_sync)
                        begin
                            // First low sample is sample one.
                            phase <= 5'h01;
                            votes <= 2'h0;
                            state <= arcdr_pkg::ARCDR_START;
                        end
                    end
                    arcdr_pkg::ARCDR_START:
                    begin
                        phase <= samp;
                        if (samp == vote_first || samp == vote_first + 5'h01)
                        begin
                            votes <= {votes[0], line_sync};
                        end
                        if (samp == vote_first + 5'h02)
                        begin
                            if (vote_bit)
                            begin
                                state <= arcdr_pkg::ARCDR_IDLE;
                            end
                            else
                            begin
                                // Bit timing keeps counting from this edge.
                                bit_idx <= 4'h0;
                                state <= arcdr_pkg::ARCDR_DATA;
                            end
                        end
                    end
                    arcdr_pkg::ARCDR_DATA,
                    arcdr_pkg::ARCDR_STOP:
                    begin
                        // Sample number wraps at 16 or 8 states per bit.
                        phase <= samp;
                        if (samp == vote_first || samp == vote_first + 5'h01)
                        begin
                            votes <= {votes[0], line_sync};
                        end
                        if (samp == vote_first + 5'h02)
                        begin
                            if (state == arcdr_pkg::ARCDR_DATA)
                            begin
                                shift <= {vote_bit, shift[9:1]};
                                bit_idx <= bit_idx + 4'h1;
                                if (bit_idx + 4'h1 == frame_len)
                                begin
                                    state <= arcdr_pkg::ARCDR_STOP;
                                end
                            end
                            else
                            begin
                                // Right-justify the frame, stop error on top.
                                push_data <= {!vote_bit,
                                    shift >> (4'hA - frame_len)};
                                push_valid <= 1'b1;
                                // Idle at once so an early start is caught.
                                state <= arcdr_pkg::ARCDR_IDLE;
                            end
                        end
                    end
                endcase
            end
        end
    end

    // Overrun marks a frame dropped because the buffer was full.
    always_ff @(posedge mclk_i)
    begin
        if (srst_i)
        begin
            overrun_o <= 1'b0;
        end
        else if (push_valid && !fifo_ready)
        begin
            overrun_o <= 1'b1;
        end
        else if (push_valid)
        begin
            overrun_o <= 1'b0;
        end
    end

    // Received frames wait in the buffer until the consumer takes them.
    arcdr_fifo #(.WIDTH(11), .DEPTH(FIFO_DEPTH)) u_fifo
    (
        .mclk_i(mclk_i),
        .srst_i(srst_i),
        .in_valid_i(push_valid),
        .in_ready_o(fifo_ready),
        .in_data_i(push_data),
        .out_valid_o(rx_valid_o),
        .out_ready_i(rx_ready_i),
        .out_data_o(pop_data)
    );
    assign rx_data_o = pop_data[9:0];
    assign frame_error_flag_o = pop_data[10];
endmodule

// *** bench/arcdr_rx_chk.sv ***
`timescale 1ns/1ps
// Watches the receiver ports for framing and buffering behaviour.
module arcdr_rx_chk
#(
    parameter int DIVW = 12
)
(
    input wire logic mclk_i,
    input wire logic srst_i,
    input wire logic serial_in_line_i,
    input wire logic double_speed_select_i,
    input wire logic [DIVW-1:0] baud_divisor_value_i,
    input wire logic [3:0] char_len_i,
    input wire logic rx_valid_o,
    input wire logic rx_ready_i,
    input wire logic [9:0] rx_data_o,
    input wire logic frame_error_flag_o,
    input wire logic overrun_o,
    input wire logic busy_o
);
    default clocking @(posedge mclk_i);
    endclocking
    default disable iff (srst_i);
    logic fast_n;
    logic fast_d;
    // One sample tick per clock, in each speed mode.
    assign fast_n = !double_speed_select_i && baud_divisor_value_i == '0;
    assign fast_d = double_speed_select_i && baud_divisor_value_i == '0;
    chk_reset_clear: assert property (
        $fell(srst_i) |-> !rx_valid_o && !busy_o && !overrun_o)
        else $error("outputs not clear after reset");
    chk_idle_quiet: assert property (
        (!busy_o && serial_in_line_i) [*6] |=> !busy_o)
        else $error("busy without a falling edge");
    chk_sync_delay: assert property (
        $fell(serial_in_line_i) && !busy_o |=> !busy_o)
        else $error("line edge seen without synchroniser delay");
    chk_qualify_hold: assert property (
        $rose(busy_o) && fast_n |-> busy_o [*8])
        else $error("start dropped before centre samples");
    chk_frame_bound: assert property (
        $rose(busy_o) && fast_n |-> ##[1:400] !busy_o)
        else $error("normal frame did not end");
    chk_double_bound: assert property (
        $rose(busy_o) && fast_d |-> ##[1:100] !busy_o)
        else $error("double speed frame did not end");
    chk_head_stable: assert property (
        rx_valid_o && !rx_ready_i |=> rx_valid_o && $stable(rx_data_o)
        && $stable(frame_error_flag_o))
        else $error("head frame changed before pop");
    chk_upper_zero: assert property (
        rx_valid_o && char_len_i == 4'h5 |-> rx_data_o[9:5] == '0)
        else $error("unused data bits not zero");
    cover property (rx_valid_o && frame_error_flag_o);
    cover property ($rose(overrun_o));
    cover property (fast_d && $rose(busy_o));
endmodule
bind arcdr_rx arcdr_rx_chk #(.DIVW(DIVW)) u_chk
(
    .mclk_i(mclk_i), .srst_i(srst_i), .serial_in_line_i(serial_in_line_i),
    .double_speed_select_i(double_speed_select_i),
    .baud_divisor_value_i(baud_divisor_value_i), .char_len_i(char_len_i),
    .rx_valid_o(rx_valid_o), .rx_ready_i(rx_ready_i),
    .rx_data_o(rx_data_o), .frame_error_flag_o(frame_error_flag_o),
    .overrun_o(overrun_o), .busy_o(busy_o)
);

// *** bench/arcdr_tx_model.sv ***
`timescale 1ns/1ps
// Remote transmitter driving the shared line, which idles high.
module arcdr_tx_model
(
    input wire logic mclk_i,
    output logic line_o
);
    initial line_o = 1'b1;
    // Sends start, len bits first bit first, then a stop level.
    task automatic send(input int bc, input int len, input logic [9:0] d,
        input logic stop, input int sc);
        line_o <= 1'b0;
        repeat (bc) @(posedge mclk_i);
        for (int i = 0; i < len; i++)
        begin
            line_o <= d[i];
            repeat (bc) @(posedge mclk_i);
        end
        line_o <= stop;
        repeat (sc) @(posedge mclk_i);
        if (!stop)
        begin
            line_o <= 1'b1;
            @(posedge mclk_i);
        end
    endtask
endmodule

// *** bench/async_rx_clock_data_recovery_tb.sv ***
`timescale 1ns/1ps
module async_rx_clock_data_recovery_tb;
    logic mclk_i = 1'b0;
    logic srst_i = 1'b1;
    logic line;
    logic dbl = 1'b0;
    logic [11:0] div = 12'h000;
    logic [3:0] clen = 4'h8;
    logic rdy = 1'b0;
    logic vld;
    logic fe;
    logic ovr;
    logic [9:0] dat;
    logic bsy;
    int error_cnt = 0;
    int total_checks = 0;
    always #25 mclk_i = ~mclk_i;
    arcdr_tx_model tx (.mclk_i(mclk_i), .line_o(line));
    arcdr_rx dut
    (
        .mclk_i(mclk_i), .srst_i(srst_i), .serial_in_line_i(line),
        .double_speed_select_i(dbl), .baud_divisor_value_i(div),
        .char_len_i(clen), .rx_valid_o(vld), .rx_ready_i(rdy),
        .rx_data_o(dat), .frame_error_flag_o(fe), .overrun_o(ovr),
        .busy_o(bsy)
    );
    // Prints the counts and the verdict, then ends the run.
    task automatic results();
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // Compares one value and reports a difference.
    task automatic chk(input logic [10:0] got, input logic [10:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // Waits for the head frame, compares it while settled, then pops it.
    task automatic take(input logic [9:0] d, input logic e);
        int i;
        i = 0;
        do
        begin
            @(negedge mclk_i);
            i++;
        end
        while (vld !== 1'b1 && i < 3000);
        if (i >= 3000)
        begin
            error_cnt++;
            $display("mismatch at %0t timeout got %h exp %h", $time, vld, 1'b1);
            results();
        end
        chk({fe, dat}, {e, d});
        @(posedge mclk_i);
        rdy <= 1'b1;
        @(posedge mclk_i);
        rdy <= 1'b0;
    endtask
    // Applies mode settings while the receiver is idle.
    task automatic cfg(input logic m, input logic [11:0] v, input int n);
        dbl <= m;
        div <= v;
        clen <= 4'(n);
        repeat (4) @(posedge mclk_i);
    endtask
    // Every frame length from five to ten bits.
    task automatic t_lengths();
        for (int n = 5; n <= 10; n++)
        begin
            cfg(1'b0, 12'h000, n);
            tx.send(16, n, 10'h2B5, 1'b1, 16);
            take(10'h2B5 & ((10'h001 << n) - 10'h001), 1'b0);
        end
    endtask
    // Double speed, good and bad stop bits.
    task automatic t_double();
        cfg(1'b1, 12'h000, 8);
        tx.send(8, 8, 10'h0A5, 1'b1, 8);
        take(10'h0A5, 1'b0);
        tx.send(8, 8, 10'h05A, 1'b0, 8);
        take(10'h05A, 1'b1);
    endtask
    // Frame error, then a start right after the stop vote.
    task automatic t_errors();
        cfg(1'b0, 12'h000, 8);
        tx.send(16, 8, 10'h0C3, 1'b0, 16);
        tx.send(16, 8, 10'h03C, 1'b1, 10);
        tx.send(16, 8, 10'h081, 1'b1, 16);
        take(10'h0C3, 1'b1);
        take(10'h03C, 1'b0);
        take(10'h081, 1'b0);
    endtask
    // A short low spike is dropped as noise.
    task automatic t_noise();
        cfg(1'b0, 12'h000, 6);
        tx.send(5, 0, 10'h000, 1'b1, 20);
        tx.send(16, 6, 10'h02D, 1'b1, 16);
        take(10'h02D, 1'b0);
        repeat (40) @(posedge mclk_i);
        chk({10'h000, vld}, 11'h000);
        chk({10'h000, bsy}, 11'h000);
    endtask
    // Slow then fast sender, four clocks per sample.
    task automatic t_rate();
        cfg(1'b0, 12'h003, 8);
        tx.send(66, 8, 10'h0E1, 1'b1, 66);
        tx.send(63, 8, 10'h01E, 1'b1, 63);
        take(10'h0E1, 1'b0);
        take(10'h01E, 1'b0);
    endtask
    // Fills the buffer past full, then drains it in order.
    task automatic t_overrun();
        cfg(1'b0, 12'h000, 5);
        for (int k = 0; k < 17; k++)
            tx.send(16, 5, 10'(k), 1'b1, 16);
        repeat (20) @(posedge mclk_i);
        chk({10'h000, ovr}, 11'h001);
        for (int k = 0; k < 16; k++)
            take(10'(k), 1'b0);
        tx.send(16, 5, 10'h015, 1'b1, 16);
        take(10'h015, 1'b0);
        chk({10'h000, ovr}, 11'h000);
    endtask
    // Main sequence.
    initial
    begin
        repeat (20) @(posedge mclk_i);
        srst_i <= 1'b0;
        repeat (4) @(posedge mclk_i);
        t_lengths();
        t_double();
        t_errors();
        t_noise();
        t_rate();
        t_overrun();
        results();
    end
endmodule
